// *** design/bcc_encoder_cmd.sv ***
// Purpose: Command, trigger and frame reception for one serial encoder channel
// Assumes: Phase, servo and encoder data inputs are asynchronous to i_mclk
// Notes:   The encoder clock line idles high and toggles on each intermediate tick
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module bcc_encoder_cmd #(
  parameter int SER_DIV = bcc_pkg::SER_DIV_DEF
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_phase_clk,
  input  wire logic        i_servo_clk,
  input  wire logic        i_enc_data,
  output logic             o_enc_clk,
  output logic             o_irq
);

  localparam int DIV_W = $clog2(SER_DIV);

  if (SER_DIV < 4 || SER_DIV > 255)
    $error("SER_DIV must lie in 4..255");

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] width_mask(input logic [3:0] w);
    width_mask = 8'((9'h001 << w) - 9'h001);
  endfunction

  function automatic logic [3:0] msb_width(input logic [7:0] m);
    msb_width = 4'h0;
    for (int i = 0; i < 8; i++)
      if (m[i])
        msb_width = 4'(i + 1);
  endfunction

  // Serial CRC: bit k of the mask taps X^(k+1), X^0 always tapped
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b,
                                          input logic [7:0] m, input logic [3:0] w);
    logic       fb;
    logic [7:0] n;
    fb = c[3'(w - 4'h1)] ^ b;
    n = {c[6:0], 1'b0} ^ ({m[6:0], 1'b1} & {8{fb}});
    crc_step = n & width_mask(w);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: only the second stage is read
  logic [1:0] phase_sync_q;
  logic [1:0] servo_sync_q;
  logic [1:0] data_sync_q;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      phase_sync_q <= 2'h0;
      servo_sync_q <= 2'h0;
      data_sync_q  <= 2'h3;
    end
    else
    begin
      phase_sync_q <= {phase_sync_q[0], i_phase_clk};
      servo_sync_q <= {servo_sync_q[0], i_servo_clk};
      data_sync_q  <= {data_sync_q[0], i_enc_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  bcc_pkg::bcc_cmd_t   cmd_q, cmd_d;
  bcc_pkg::bcc_tctl_t  tctl_q, tctl_d;
  bcc_pkg::bcc_state_t state_q, state_d;
  logic [DIV_W-1:0]    div_q, div_d;
  logic                trig_prev_q, trig_prev_d;
  logic [7:0]          dly_q, dly_d;
  logic                ma_q, ma_d;
  logic                ma_first_q, ma_first_d;
  logic [bcc_pkg::SR_W-1:0] sr_q, sr_d;
  logic [7:0]          crc_q, crc_d;
  logic [7:0]          crc_rx_q, crc_rx_d;
  logic [5:0]          bit_cnt_q, bit_cnt_d;
  logic [5:0]          pos_n_q, pos_n_d;
  logic [3:0]          stat_n_q, stat_n_d;
  logic [3:0]          crc_w_q, crc_w_d;
  logic [7:0]          crc_m_q, crc_m_d;
  logic [39:0]         pos_q, pos_d;
  logic [5:0]          stat_q, stat_d;
  logic                crc_err_q, crc_err_d;
  logic [1:0]          irq_stat_q, irq_stat_d;
  logic [1:0]          irq_mask_q, irq_mask_d;
  logic                irq_q, irq_d;
  logic                wait_q, wait_d;
  logic [31:0]         rdata_q, rdata_d;

  logic                ser_tick;
  logic                trig_lvl;
  logic                trig_edge;
  logic                sample;
  logic                frame_end;
  logic                acc;
  logic [31:0]         bmask;
  logic [31:0]         wmerge;
  logic [6:0]          ds_n;
  logic                crc_ok;

  always_comb
  begin
    ser_tick  = (div_q == DIV_W'(SER_DIV - 1));
    trig_lvl  = tctl_q.clock_servo ? servo_sync_q[1] : phase_sync_q[1];
    trig_edge = tctl_q.edge_falling ? (trig_prev_q & ~trig_lvl) : (~trig_prev_q & trig_lvl);
    // Sample on each falling encoder clock tick except the very first
    sample    = ser_tick & ma_q & ~ma_first_q;
    ds_n      = 7'(pos_n_q) + 7'(stat_n_q);
    frame_end = (state_q == bcc_pkg::ST_TAIL) & data_sync_q[1];
    crc_ok    = (crc_rx_q == (~crc_q & width_mask(crc_w_q)));
    acc       = (i_avs_read | i_avs_write) & wait_q;
    bmask     = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    div_d       = ser_tick ? '0 : div_q + DIV_W'(1);
    trig_prev_d = trig_lvl;
    state_d     = state_q;
    cmd_d       = cmd_q;
    tctl_d      = tctl_q;
    dly_d       = dly_q;
    ma_d        = ma_q;
    ma_first_d  = ma_first_q;
    sr_d        = sr_q;
    crc_d       = crc_q;
    crc_rx_d    = crc_rx_q;
    bit_cnt_d   = bit_cnt_q;
    pos_n_d     = pos_n_q;
    stat_n_d    = stat_n_q;
    crc_w_d     = crc_w_q;
    crc_m_d     = crc_m_q;
    pos_d       = pos_q;
    stat_d      = stat_q;
    crc_err_d   = crc_err_q;
    irq_mask_d  = irq_mask_q;
    irq_stat_d  = irq_stat_q;
    wait_d      = 1'b1;
    rdata_d     = rdata_q;

    unique case (state_q)
      bcc_pkg::ST_IDLE:
      begin
        // Single mode also waits for the selected clock edge
        if (tctl_q.encoder_port_enable && cmd_q.sample_trigger_enable && trig_edge)
        begin
          state_d  = bcc_pkg::ST_DELAY;
          dly_d    = tctl_q.trigger_delay_count;
          cmd_d.reception_done_flag = 1'b0;
          // Counts are frozen per frame so a mid-frame write cannot tear it
          pos_n_d  = (cmd_q.position_bit_count < bcc_pkg::POS_MIN) ? bcc_pkg::POS_MIN :
                     (cmd_q.position_bit_count > bcc_pkg::POS_MAX) ? bcc_pkg::POS_MAX :
                     cmd_q.position_bit_count;
          stat_n_d = (cmd_q.status_bit_count > bcc_pkg::STAT_MAX) ? bcc_pkg::STAT_MAX :
                     cmd_q.status_bit_count;
          crc_m_d  = cmd_q.crc_mask;
          crc_w_d  = msb_width(cmd_q.crc_mask);
        end
      end
      bcc_pkg::ST_DELAY:
      begin
        if (ser_tick)
        begin
          if (dly_q == 8'h00)
          begin
            state_d    = bcc_pkg::ST_ACK;
            ma_first_d = 1'b1;
          end
          else
            dly_d = dly_q - 8'h01;
        end
      end
      bcc_pkg::ST_ACK, bcc_pkg::ST_START, bcc_pkg::ST_CDS:
      begin
        if (ser_tick)
        begin
          ma_d       = ~ma_q;
          ma_first_d = 1'b0;
        end
        if (sample)
        begin
          if (state_q == bcc_pkg::ST_ACK && !data_sync_q[1])
            state_d = bcc_pkg::ST_START;
          else if (state_q == bcc_pkg::ST_START && data_sync_q[1])
            state_d = bcc_pkg::ST_CDS;
          else if (state_q == bcc_pkg::ST_CDS)
          begin
            state_d   = bcc_pkg::ST_DATA;
            bit_cnt_d = 6'h00;
            sr_d      = '0;
            crc_d     = 8'h00;
            crc_rx_d  = 8'h00;
          end
        end
      end
      bcc_pkg::ST_DATA:
      begin
        if (ser_tick)
          ma_d = ~ma_q;
        if (sample)
        begin
          bit_cnt_d = bit_cnt_q + 6'h01;
          if (7'(bit_cnt_q) < ds_n)
          begin
            sr_d = {sr_q[bcc_pkg::SR_W-2:0], data_sync_q[1]};
            if (crc_w_q != 4'h0)
              crc_d = crc_step(crc_q, data_sync_q[1], crc_m_q, crc_w_q);
          end
          else
            crc_rx_d = {crc_rx_q[6:0], data_sync_q[1]};
          if (7'(bit_cnt_q) + 7'h01 == ds_n + 7'(crc_w_q))
          begin
            state_d = bcc_pkg::ST_TAIL;
            ma_d    = 1'b1;
          end
        end
      end
      bcc_pkg::ST_TAIL:
      begin
        // Encoder releases the data line high once its timeout ends
        if (data_sync_q[1])
        begin
          state_d   = bcc_pkg::ST_IDLE;
          pos_d     = 40'(sr_q >> stat_n_q);
          stat_d    = 6'(sr_q) & 6'(width_mask(stat_n_q));
          crc_err_d = ~crc_ok;
          cmd_d.reception_done_flag = 1'b1;
          if (cmd_q.sample_repeat_select)
            cmd_d.sample_trigger_enable = 1'b0;
        end
      end
    endcase

    if (!tctl_q.encoder_port_enable)
    begin
      state_d = bcc_pkg::ST_IDLE;
      ma_d    = 1'b1;
    end

    // Hardware events set sticky bits; a set in the clearing cycle survives
    if (acc && i_avs_write && i_avs_address == bcc_pkg::OFF_IRQ_STAT)
      irq_stat_d = irq_stat_q & ~i_avs_writedata[1:0];
    irq_stat_d[bcc_pkg::IRQ_DONE] = irq_stat_d[bcc_pkg::IRQ_DONE] | frame_end;
    irq_stat_d[bcc_pkg::IRQ_CRC]  = irq_stat_d[bcc_pkg::IRQ_CRC] | (frame_end & ~crc_ok);

    if (acc)
    begin
      wait_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      unique case (i_avs_address)
        bcc_pkg::OFF_CMD:      rdata_d = cmd_q;
        bcc_pkg::OFF_TCTL:     rdata_d = tctl_q;
        bcc_pkg::OFF_POS_LO:   rdata_d = pos_q[31:0];
        bcc_pkg::OFF_POS_HI:   rdata_d = {15'h0000, crc_err_q, 2'h0, stat_q, pos_q[39:32]};
        bcc_pkg::OFF_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
        bcc_pkg::OFF_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
        default:               rdata_d = 32'h0000_0000;
      endcase
      if (i_avs_write)
      begin
        // A software write wins over the hardware clear of the trigger enable
        wmerge = (cmd_d & ~bmask) | (i_avs_writedata & bmask);
        if (i_avs_address == bcc_pkg::OFF_CMD)
          cmd_d = (wmerge & bcc_pkg::CMD_WMASK) | {21'h0, cmd_d.reception_done_flag, 10'h0};
        wmerge = (tctl_q & ~bmask) | (i_avs_writedata & bmask);
        if (i_avs_address == bcc_pkg::OFF_TCTL)
          tctl_d = wmerge & bcc_pkg::TCTL_WMASK;
        if (i_avs_address == bcc_pkg::OFF_IRQ_MASK && i_avs_byteenable[0])
          irq_mask_d = i_avs_writedata[1:0];
      end
    end
    wmerge = 32'h0000_0000;
    irq_d  = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state_q     <= bcc_pkg::ST_IDLE;
      cmd_q       <= bcc_pkg::CMD_RESET;
      tctl_q      <= bcc_pkg::TCTL_RESET;
      div_q       <= '0;
      trig_prev_q <= 1'b0;
      dly_q       <= 8'h00;
      ma_q        <= 1'b1;
      ma_first_q  <= 1'b0;
      sr_q        <= '0;
      crc_q       <= 8'h00;
      crc_rx_q    <= 8'h00;
      bit_cnt_q   <= 6'h00;
      pos_n_q     <= bcc_pkg::POS_MIN;
      stat_n_q    <= 4'h0;
      crc_w_q     <= 4'h0;
      crc_m_q     <= 8'h00;
      pos_q       <= 40'h00_0000_0000;
      stat_q      <= 6'h00;
      crc_err_q   <= 1'b0;
      irq_stat_q  <= 2'h0;
      irq_mask_q  <= 2'h0;
      irq_q       <= 1'b0;
      wait_q      <= 1'b1;
      rdata_q     <= 32'h0000_0000;
    end
    else
    begin
      state_q     <= state_d;
      cmd_q       <= cmd_d;
      tctl_q      <= tctl_d;
      div_q       <= div_d;
      trig_prev_q <= trig_prev_d;
      dly_q       <= dly_d;
      ma_q        <= ma_d;
      ma_first_q  <= ma_first_d;
      sr_q        <= sr_d;
      crc_q       <= crc_d;
      crc_rx_q    <= crc_rx_d;
      bit_cnt_q   <= bit_cnt_d;
      pos_n_q     <= pos_n_d;
      stat_n_q    <= stat_n_d;
      crc_w_q     <= crc_w_d;
      crc_m_q     <= crc_m_d;
      pos_q       <= pos_d;
      stat_q      <= stat_d;
      crc_err_q   <= crc_err_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
      irq_q       <= irq_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_enc_clk         = ma_q;
  assign o_irq             = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  logic sw_cmd_wr;
  assign sw_cmd_wr = acc & i_avs_write & (i_avs_address == bcc_pkg::OFF_CMD);

  sequence s_frame_start;
    state_q == bcc_pkg::ST_IDLE && state_d == bcc_pkg::ST_DELAY;
  endsequence

  sequence s_frame_done;
    frame_end && tctl_q.encoder_port_enable;
  endsequence

  chk_crc_width: assert property (s_frame_start |=> crc_w_q == msb_width($past(cmd_q.crc_mask)))
    else $error("CRC width not taken from mask");
  chk_mode_clear: assert property (s_frame_done ##0 !cmd_q.sample_repeat_select && !sw_cmd_wr
                                   |=> cmd_q.sample_trigger_enable || !$past(cmd_q.sample_trigger_enable))
    else $error("Repeat mode dropped trigger enable");
  chk_repeat_start: assert property (state_q == bcc_pkg::ST_IDLE && trig_edge && cmd_q.sample_trigger_enable
                                     && tctl_q.encoder_port_enable |=> state_q == bcc_pkg::ST_DELAY)
    else $error("Trigger edge did not start a read");
  chk_trig_gate: assert property (state_q == bcc_pkg::ST_IDLE && !cmd_q.sample_trigger_enable
                                  |=> state_q == bcc_pkg::ST_IDLE)
    else $error("Read started with trigger disabled");
  chk_oneshot_clear: assert property (s_frame_done ##0 cmd_q.sample_repeat_select && !sw_cmd_wr
                                      |=> !cmd_q.sample_trigger_enable ##1 state_q == bcc_pkg::ST_IDLE)
    else $error("Single read did not clear trigger enable");
  chk_done_flag: assert property (s_frame_start |=> !cmd_q.reception_done_flag
                                  throughout (state_q != bcc_pkg::ST_IDLE)[*3])
    else $error("Done flag high during reception");
  chk_bit_count: assert property (state_q == bcc_pkg::ST_DATA && state_d == bcc_pkg::ST_TAIL && sample
                                  |-> 7'(bit_cnt_q) + 7'h01 == 7'(pos_n_q) + 7'(stat_n_q) + 7'(crc_w_q))
    else $error("Frame length differs from programmed counts");
  chk_stat_limit: assert property (s_frame_start |=> stat_n_q <= bcc_pkg::STAT_MAX && pos_n_q <= bcc_pkg::POS_MAX)
    else $error("Status or position count out of range");
  chk_port_gate: assert property (!tctl_q.encoder_port_enable |=> state_q == bcc_pkg::ST_IDLE && o_enc_clk)
    else $error("Encoder active while port disabled");
  chk_delay_hold: assert property (state_q == bcc_pkg::ST_DELAY && dly_q != 8'h00 && tctl_q.encoder_port_enable
                                   |=> state_q == bcc_pkg::ST_DELAY)
    else $error("Delay ended early");
  chk_crc_flag: assert property (s_frame_done |=> crc_err_q == !$past(crc_ok) && irq_stat_q[bcc_pkg::IRQ_DONE])
    else $error("CRC result not recorded");

endmodule

// *** design/bcc_pkg.sv ***
// Purpose: Shared constants and types of the serial encoder command block
// Assumes: Avalon-MM slave with byte addresses, one 32-bit word per register
// Notes:   Register layouts travel as packed structs, reserved fields read zero
//
// Summary of operation
// - The CRC polynomial comes from mask bits 23..16, mask bit n weighting X^(n+1), plus a constant 1.
// - Command bit 13 picks repeated sampling at 0 and a single sample at 1.
// - In repeated mode a read starts on each selected edge of the phase or servo clock that arrives while the channel is idle.
// - Command bit 12 enables triggering; reads repeat while it is 1 and none start while it is 0.
// - In single mode a set trigger enable gives one read and is cleared by hardware when it completes.
// - Command bit 10 reads 0 while a frame is being received and 1 once it is done, and ignores writes.
// - Bits 9..6 give 0 to 6 status bits after the position word, and that many are received.
// - Bits 5..0 give a position word of 12 to 40 bits, and that many are received.
// - A channel enable, reset to off, gates the whole encoder interface; no read starts while it is off.
// - Each read starts a programmable delay of 0 to 255 intermediate clock cycles after the trigger edge.
package bcc_pkg;

  localparam logic [4:0]  OFF_CMD      = 5'h00;
  localparam logic [4:0]  OFF_TCTL     = 5'h04;
  localparam logic [4:0]  OFF_POS_LO   = 5'h08;
  localparam logic [4:0]  OFF_POS_HI   = 5'h0c;
  localparam logic [4:0]  OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0]  OFF_IRQ_MASK = 5'h14;

  localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
  localparam logic [31:0] TCTL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CMD_WMASK    = 32'h00ff_33ff;
  localparam logic [31:0] TCTL_WMASK   = 32'h0000_ff07;

  localparam logic [5:0]  POS_MIN      = 6'h0c;
  localparam logic [5:0]  POS_MAX      = 6'h28;
  localparam logic [3:0]  STAT_MAX     = 4'h6;
  localparam int          SR_W         = 46;
  localparam int          SER_DIV_DEF  = 25;

  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_CRC      = 1;

  typedef struct packed {
    logic [7:0] rsv_hi;
    logic [7:0] crc_mask;
    logic [1:0] rsv_mid;
    logic       sample_repeat_select;
    logic       sample_trigger_enable;
    logic       rsv_lo;
    logic       reception_done_flag;
    logic [3:0] status_bit_count;
    logic [5:0] position_bit_count;
  } bcc_cmd_t;

  typedef struct packed {
    logic [15:0] rsv_hi;
    logic [7:0]  trigger_delay_count;
    logic [4:0]  rsv_lo;
    logic        edge_falling;
    logic        clock_servo;
    logic        encoder_port_enable;
  } bcc_tctl_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_ACK, ST_START, ST_CDS, ST_DATA, ST_TAIL
  } bcc_state_t;

endpackage

// *** bench/bcc_enc_model.sv ***
// Purpose: Behavioural serial position encoder facing the command block
// Assumes: Data changes after each rising encoder clock edge
// Notes:   Line idles high; the last bit is released after a hold time
`timescale 1ns/1ps
module bcc_enc_model (
  input  wire logic        i_enc_clk,
  input  wire logic [7:0]  i_mask,
  input  wire logic [5:0]  i_pos_n,
  input  wire logic [3:0]  i_stat_n,
  input  wire logic [39:0] i_pos,
  input  wire logic [5:0]  i_stat,
  input  wire logic [3:0]  i_ack_extra,
  input  wire logic        i_bad_crc,
  output logic             o_enc_data,
  output int               o_frames
);
  logic       q[$];
  logic [7:0] crc;
  logic       busy;
  int         w;
  initial
  begin
    o_enc_data = 1'b1;
    o_frames = 0;
    busy = 1'b0;
  end
  task automatic add_bit(input logic b);
    logic fb;
    fb = (w > 0) ? (crc[w-1] ^ b) : 1'b0;
    q.push_back(b);
    crc = {crc[6:0], 1'b0} ^ (fb ? {i_mask[6:0], 1'b1} : 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge i_enc_clk)
    if (!busy)
    begin
      busy = 1'b1;
      o_frames++;
      crc = 8'h00;
      w = 0;
      for (int k = 0; k < 8; k++) if (i_mask[k]) w = k + 1;
      // A slow encoder holds acknowledge for extra clocks
      repeat (i_ack_extra + 1) q.push_back(1'b0);
      q.push_back(1'b1);
      q.push_back(1'b0);
      for (int k = 39; k >= 0; k--) if (k < i_pos_n) add_bit(i_pos[k]);
      for (int k = 5; k >= 0; k--) if (k < i_stat_n) add_bit(i_stat[k]);
      for (int k = 7; k >= 0; k--) if (k < w) q.push_back(~crc[k] ^ (i_bad_crc && k == 0));
    end
  always @(posedge i_enc_clk)
    if (busy && q.size() > 0)
    begin
      o_enc_data = q.pop_front();
      // No clock follows the last bit, so the hold time runs out by itself
      if (q.size() == 0)
        fork
          begin
            #200;
            o_enc_data = 1'b1;
            busy = 1'b0;
          end
        join_none
    end
endmodule

// *** bench/testbench.sv ***
// Purpose: Self-checking bench of the serial encoder command block
// Assumes: Avalon answers come within 64 cycles, frames within 20000
// Notes:   Short encoder tick keeps the run brief
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  localparam int SD = 10;
  typedef struct {
    logic [7:0] mask; logic [5:0] pn; logic [3:0] sn; logic [39:0] pos;
    logic [5:0] st;   logic [3:0] ack; logic bad;
  } bcc_row_t;
  logic        mclk, rst_n, rd, wr, phase, servo, enc_data, enc_clk, irq, waitreq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, r, cmd;
  int          err_count, comparisons, frames, n, f0, d;
  bcc_row_t    rows [5];
  bcc_row_t    cur;
  bcc_encoder_cmd #(.SER_DIV(SD)) i_bcc_encoder_cmd (.i_mclk(mclk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_phase_clk(phase), .i_servo_clk(servo),
    .i_enc_data(enc_data), .o_enc_clk(enc_clk), .o_irq(irq));
  bcc_enc_model i_bcc_enc_model (.i_enc_clk(enc_clk), .i_mask(cur.mask), .i_pos_n(cur.pn), .i_stat_n(cur.sn),
    .i_pos(cur.pos), .i_stat(cur.st), .i_ack_extra(cur.ack), .i_bad_crc(cur.bad), .o_enc_data(enc_data),
    .o_frames(frames));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always
  begin
    repeat (10) @(posedge mclk);
    phase <= ~phase;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dw, output logic [31:0] q);
    int k;
    @(posedge mclk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= dw;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end while (waitreq !== 1'b0 && k < 64);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 64)
    begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wirq(input logic e);
    repeat (3) @(posedge mclk);
    `CHK(irq, e)
  endtask
  task automatic arm();
    cmd = {8'h00, cur.mask, 4'b0011, 2'b00, cur.sn, cur.pn};
    f0 = frames;
    bus(1'b1, 5'h00, cmd, r);
  endtask
  task automatic finish_frame();
    n = 0;
    while (irq !== 1'b1 && n < 20000)
    begin
      @(posedge mclk);
      n++;
    end
    `CHK(irq, 1'b1)
    if (n >= 20000)
      end_of_test();
    repeat (100) @(posedge mclk);
    `CHK(frames - f0, 1)
    bus(1'b0, 5'h08, 32'h0, r);
    `CHK(r, cur.pos[31:0])
    bus(1'b0, 5'h0c, 32'h0, r);
    `CHK(r, {15'h0, cur.bad, 2'b00, cur.st, cur.pos[39:32]})
    bus(1'b0, 5'h00, 32'h0, r);
    `CHK(r, (cmd & ~32'h0000_1000) | 32'h0000_0400)
    bus(1'b0, 5'h10, 32'h0, r);
    `CHK(r, {30'h0, cur.bad, 1'b1})
    bus(1'b1, 5'h10, 32'h1, r);
    wirq(1'b0);
    if (cur.bad)
    begin
      bus(1'b1, 5'h14, 32'h3, r);
      wirq(1'b1);
      bus(1'b1, 5'h10, 32'h2, r);
      bus(1'b1, 5'h14, 32'h1, r);
      wirq(1'b0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    phase = 1'b0;
    servo = 1'b0;
    rows[0] = '{8'h21, 6'h0c, 4'h0, 40'h00_0000_0a5c, 6'h00, 4'h0, 1'b0};
    rows[1] = '{8'h80, 6'h28, 4'h6, 40'hc3_5a5a_0f0f, 6'h2d, 4'h3, 1'b0};
    rows[2] = '{8'h01, 6'h19, 4'h3, 40'h00_0123_4567, 6'h05, 4'h1, 1'b0};
    rows[3] = '{8'h21, 6'h20, 4'h2, 40'h00_dead_beef, 6'h02, 4'h0, 1'b1};
    rows[4] = '{8'h00, 6'h28, 4'h1, 40'h80_0000_0001, 6'h01, 4'h2, 1'b0};
    cur = rows[0];
    repeat (8) @(posedge mclk);
    `CHK(enc_clk, 1'b1)
    rst_n <= 1'b1;
    bus(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h0)
    bus(1'b0, 5'h04, 32'h0, r);
    `CHK(r, 32'h0)
    bus(1'b0, 5'h18, 32'h0, r);
    `CHK(r, 32'h0)
    // Trigger armed while the channel is off must stay silent
    bus(1'b1, 5'h00, 32'hffff_ffff, r);
    repeat (400) @(posedge mclk);
    `CHK(frames, 0)
    bus(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h00ff_33ff)
    bus(1'b1, 5'h00, 32'h0, r);
    bus(1'b1, 5'h14, 32'h1, r);
    bus(1'b1, 5'h04, 32'h1, r);
    foreach (rows[i])
    begin
      cur = rows[i];
      arm();
      finish_frame();
    end
    // Servo edges, rising then falling, with the shortest and longest delay
    cur = rows[0];
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 255 : 0;
      bus(1'b1, 5'h04, {16'h0, d[7:0], 5'h00, i[0], 2'b11}, r);
      arm();
      repeat (20) @(posedge mclk);
      `CHK(frames - f0, 0)
      servo <= ~servo;
      n = 0;
      while (enc_clk !== 1'b0 && n < 4000)
      begin
        @(posedge mclk);
        n++;
      end
      // Sync and edge take 3 cycles, then delay+1 ticks, then one tick to the first fall
      `CHK(n >= (d + 1) * SD + 5 && n <= (d + 2) * SD + 4, 1'b1)
      if (n >= 4000)
        end_of_test();
      finish_frame();
    end
    // Continuous reads on the phase clock, then stopped
    bus(1'b1, 5'h04, 32'h1, r);
    f0 = frames;
    bus(1'b1, 5'h00, {8'h00, cur.mask, 4'b0001, 2'b00, cur.sn, cur.pn}, r);
    repeat (6000) @(posedge mclk);
    bus(1'b0, 5'h00, 32'h0, r);
    `CHK(r[12], 1'b1)
    n = frames - f0;
    `CHK(n >= 9 && n <= 16, 1'b1)
    bus(1'b1, 5'h00, {8'h00, cur.mask, 4'b0000, 2'b00, cur.sn, cur.pn}, r);
    repeat (1500) @(posedge mclk);
    f0 = frames;
    repeat (2000) @(posedge mclk);
    `CHK(frames - f0, 0)
    // Reset in mid-run must return the command and control registers to zero and the encoder clock high
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, 5'h00, 32'h0, r);
    `CHK(r, 32'h0)
    bus(1'b0, 5'h04, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(enc_clk, 1'b1)
    end_of_test();
  end
endmodule
